// File: rtl/can_bridge_pkg.sv
// Purpose: shared constants of the two-port classic/fd frame bridge
// Assumes: 32-bit ahb-lite register window, byte offsets below
// Notes: port p registers sit at p * PORT_STRIDE
//
// Functional notes
// - fd mode takes both kinds; classic only classic
// - per-port fd variant: standard or pre-standard
// - arbitration rate valid 10 to 1000 kbps
// - data-phase rate valid 100 to 10000 kbps
// - classic receiver: defaults by transmit port mode
// - fd receiver defaults; illegal paths have no effect
// - same-type paths forward frame unmodified
// - fd to classic keeps first 8 bytes
// - classic to fd without stuffing keeps payload
// - stuffing pads length-8 frames with stuff byte
// - promoted frames optionally use bit-rate switching
// - separate standard/extended remote frame rejection
// - whitelist: only matching same-type identifiers pass
// - entries are ranges, individually added or removed
// - filter changes act only after commit
// - whole configuration readable and writable
package can_bridge_pkg;
  localparam logic [8:0] PORT_STRIDE = 9'h100;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_ARB = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_SP = 8'h0C;
  localparam logic [7:0] OFF_PATH = 8'h10;
  localparam logic [7:0] OFF_STUFF = 8'h14;
  localparam logic [7:0] OFF_FILT = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1C;
  localparam logic [7:0] OFF_ENTRY = 8'h40;
  localparam logic [7:0] ENTRY_STRIDE = 8'h10;
  localparam int MODE_FD = 0;
  localparam int MODE_ISO = 1;
  localparam int PATH_CC = 0;
  localparam int PATH_CF = 1;
  localparam int PATH_FC = 2;
  localparam int PATH_FF = 3;
  localparam int PATH_STUFF = 4;
  localparam int PATH_BRS = 5;
  localparam int FILT_REJ_STD = 0;
  localparam int FILT_REJ_EXT = 1;
  localparam int CMD_COMMIT = 0;
  localparam int ENT_VALID = 0;
  localparam int ENT_EXT = 1;
  localparam int STUFF_LEN_LSB = 8;
  localparam int CNT_LSB = 16;
  localparam logic [1:0] MODE_RST = 2'h3;
  localparam logic [13:0] ARB_RST = 14'h01F4;
  localparam logic [13:0] DATA_RST = 14'h07D0;
  localparam logic [31:0] SP_RST = 32'h1F40_1F40;
  localparam logic [5:0] PATH_RST = 6'h09;
  localparam logic [7:0] STUFF_BYTE_RST = 8'hFF;
  localparam logic [6:0] STUFF_LEN_RST = 7'h10;
  localparam logic [13:0] ARB_MIN = 14'h000A;
  localparam logic [13:0] ARB_MAX = 14'h03E8;
  localparam logic [13:0] DATA_MIN = 14'h0064;
  localparam logic [13:0] DATA_MAX = 14'h2710;
  localparam logic [6:0] CLASSIC_MAX_LEN = 7'h08;
  localparam logic [6:0] FD_MAX_LEN = 7'h40;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// File: rtl/can_fd_bridge_forwarding.sv
// Purpose: two-port classic/fd bridge core with settings over ahb-lite
// Assumes: frame ports come from controllers on clk_i, no crossing
// Notes: zero wait states; port 0 is first_bus_port, 1 second_bus_port
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module can_fd_bridge_forwarding #(
  parameter int ENTRIES = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // received frames
  input wire logic [1:0] rx_hdr_valid_i,
  input wire logic [1:0][28:0] rx_id_i,
  input wire logic [1:0] rx_ext_i,
  input wire logic [1:0] rx_rtr_i,
  input wire logic [1:0] rx_fd_i,
  input wire logic [1:0] rx_brs_i,
  input wire logic [1:0][6:0] rx_len_i,
  input wire logic [1:0] rx_byte_valid_i,
  input wire logic [1:0][7:0] rx_byte_i,
  // frames to transmit
  output logic [1:0] tx_hdr_valid_o,
  output logic [1:0][28:0] tx_id_o,
  output logic [1:0] tx_ext_o,
  output logic [1:0] tx_rtr_o,
  output logic [1:0] tx_fd_o,
  output logic [1:0] tx_brs_o,
  output logic [1:0][6:0] tx_len_o,
  output logic [1:0] tx_byte_valid_o,
  output logic [1:0][7:0] tx_byte_o,
  // bus settings
  output logic [1:0] fd_mode_o,
  output logic [1:0] fd_iso_o,
  output logic [1:0][13:0] arb_rate_o,
  output logic [1:0][13:0] data_rate_o,
  output logic [1:0][31:0] sample_point_setting_o
);
  if (ENTRIES < 1 || ENTRIES > 8) begin : g_bad
    $error("ENTRIES must be 1 to 8");
  end
  logic [1:0][1:0] mode, next_mode;
  logic [1:0][13:0] arb, next_arb, drate, next_drate;
  logic [1:0][31:0] sp, next_sp;
  logic [1:0][5:0] path, next_path;
  logic [1:0][7:0] stuff_byte, next_stuff_byte;
  logic [1:0][6:0] stuff_len, next_stuff_len;
  logic [1:0][1:0] filt_st, next_filt_st, filt_act, next_filt_act;
  logic [1:0][ENTRIES-1:0][1:0] ent_st, next_ent_st, ent_act, next_ent_act;
  logic [1:0][ENTRIES-1:0][28:0] lo_st, next_lo_st, lo_act, next_lo_act, hi_st, next_hi_st, hi_act, next_hi_act;
  logic [1:0][15:0] fwd_cnt, next_fwd_cnt;
  logic [1:0] busy, accept, fwd_pulse;
  logic rst_meta, rst_n, wr_pend, next_wr_pend, wr_map, next_wr_map, ahb_go, wp, rp;
  logic [8:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata, rd_val;
  logic [7:0] wo, ro, we, re;
  logic [2:0] rd_ent;

  function automatic logic [3:0] def_paths(input logic rx_fd, input logic tx_fd);
    logic [3:0] p;
    p = 4'h0;
    if (!rx_fd) begin
      p[can_bridge_pkg::PATH_CC] = ~tx_fd;
      p[can_bridge_pkg::PATH_CF] = tx_fd;
    end else begin
      p[can_bridge_pkg::PATH_CC] = 1'b1;
      p[can_bridge_pkg::PATH_FC] = ~tx_fd;
      p[can_bridge_pkg::PATH_FF] = tx_fd;
    end
    return p;
  endfunction

  function automatic logic in_range(input logic [13:0] v, lo, hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic is_entry(input logic [7:0] off);
    return (off >= can_bridge_pkg::OFF_ENTRY)
      && (off - can_bridge_pkg::OFF_ENTRY < 8'(ENTRIES * 16));
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      accept[p] = 1'b0;
      for (int e = 0; e < ENTRIES; e++) begin
        if (ent_act[p][e][can_bridge_pkg::ENT_VALID]
            && ent_act[p][e][can_bridge_pkg::ENT_EXT] == rx_ext_i[p]
            && rx_id_i[p] >= lo_act[p][e] && rx_id_i[p] <= hi_act[p][e]) begin
          accept[p] = 1'b1;
        end
      end
      if (rx_rtr_i[p] && (rx_ext_i[p] ? filt_act[p][can_bridge_pkg::FILT_REJ_EXT]
          : filt_act[p][can_bridge_pkg::FILT_REJ_STD])) begin
        accept[p] = 1'b0;
      end
    end
  end

  always_comb begin
    rp = haddr_i[8];
    ro = haddr_i[7:0];
    re = ro - can_bridge_pkg::OFF_ENTRY;
    rd_ent = re[6:4];
    rd_val = 32'h0000_0000;
    case (ro)
      can_bridge_pkg::OFF_MODE: rd_val[1:0] = mode[rp];
      can_bridge_pkg::OFF_ARB: rd_val[13:0] = arb[rp];
      can_bridge_pkg::OFF_DATA: rd_val[13:0] = drate[rp];
      can_bridge_pkg::OFF_SP: rd_val = sp[rp];
      can_bridge_pkg::OFF_PATH: rd_val[5:0] = path[rp];
      can_bridge_pkg::OFF_STUFF: rd_val[14:0] = {stuff_len[rp], stuff_byte[rp]};
      can_bridge_pkg::OFF_FILT: rd_val[1:0] = filt_st[rp];
      can_bridge_pkg::OFF_CMD: rd_val = {fwd_cnt[rp], 15'h0000, busy[rp]};
      default: begin
        if (is_entry(ro)) begin
          case (re[3:2])
            2'h0: rd_val[1:0] = ent_st[rp][rd_ent];
            2'h1: rd_val[28:0] = lo_st[rp][rd_ent];
            2'h2: rd_val[28:0] = hi_st[rp][rd_ent];
            default: rd_val = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  always_comb begin
    next_mode = mode;
    next_arb = arb;
    next_drate = drate;
    next_sp = sp;
    next_path = path;
    next_stuff_byte = stuff_byte;
    next_stuff_len = stuff_len;
    next_filt_st = filt_st;
    next_filt_act = filt_act;
    next_ent_st = ent_st;
    next_ent_act = ent_act;
    next_lo_st = lo_st;
    next_lo_act = lo_act;
    next_hi_st = hi_st;
    next_hi_act = hi_act;
    next_hrdata = hrdata_o;
    ahb_go = hsel_i & htrans_i[1] & hready_i;
    // only whole-word writes are taken
    next_wr_pend = ahb_go & hwrite_i & (hsize_i == can_bridge_pkg::HSIZE_WORD);
    next_wr_addr = haddr_i[8:0];
    next_wr_map = (haddr_i[31:9] == 23'h00_0000);
    if (ahb_go && !hwrite_i) begin
      next_hrdata = next_wr_map ? rd_val : 32'h0000_0000;
    end
    wp = wr_addr[8];
    wo = wr_addr[7:0];
    we = wo - can_bridge_pkg::OFF_ENTRY;
    for (int p = 0; p < 2; p++) begin
      next_fwd_cnt[p] = fwd_cnt[p] + {15'h0000, fwd_pulse[p]};
    end
    if (wr_pend && wr_map) begin
      case (wo)
        can_bridge_pkg::OFF_MODE: begin
          next_mode[wp] = hwdata_i[1:0];
          // a mode change reloads both directions' defaults
          next_path[wp][3:0] = def_paths(hwdata_i[can_bridge_pkg::MODE_FD],
            mode[~wp][can_bridge_pkg::MODE_FD]);
          next_path[~wp][3:0] = def_paths(mode[~wp][can_bridge_pkg::MODE_FD],
            hwdata_i[can_bridge_pkg::MODE_FD]);
        end
        can_bridge_pkg::OFF_ARB: begin
          if (in_range(hwdata_i[13:0], can_bridge_pkg::ARB_MIN, can_bridge_pkg::ARB_MAX)
              && hwdata_i[31:14] == 18'h0_0000) begin
            next_arb[wp] = hwdata_i[13:0];
          end
        end
        can_bridge_pkg::OFF_DATA: begin
          if (in_range(hwdata_i[13:0], can_bridge_pkg::DATA_MIN, can_bridge_pkg::DATA_MAX)
              && hwdata_i[31:14] == 18'h0_0000) begin
            next_drate[wp] = hwdata_i[13:0];
          end
        end
        can_bridge_pkg::OFF_SP: next_sp[wp] = hwdata_i;
        can_bridge_pkg::OFF_PATH: next_path[wp] = hwdata_i[5:0];
        can_bridge_pkg::OFF_STUFF: begin
          next_stuff_byte[wp] = hwdata_i[7:0];
          next_stuff_len[wp] = hwdata_i[can_bridge_pkg::STUFF_LEN_LSB +: 7];
        end
        can_bridge_pkg::OFF_FILT: next_filt_st[wp] = hwdata_i[1:0];
        can_bridge_pkg::OFF_CMD: begin
          if (hwdata_i[can_bridge_pkg::CMD_COMMIT]) begin
            next_filt_act[wp] = filt_st[wp];
            next_ent_act[wp] = ent_st[wp];
            next_lo_act[wp] = lo_st[wp];
            next_hi_act[wp] = hi_st[wp];
          end
        end
        default: begin
          if (is_entry(wo)) begin
            case (we[3:2])
              2'h0: next_ent_st[wp][we[6:4]] = hwdata_i[1:0];
              2'h1: next_lo_st[wp][we[6:4]] = hwdata_i[28:0];
              2'h2: next_hi_st[wp][we[6:4]] = hwdata_i[28:0];
              default: next_hi_st = hi_st;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode <= {2{can_bridge_pkg::MODE_RST}};
      arb <= {2{can_bridge_pkg::ARB_RST}};
      drate <= {2{can_bridge_pkg::DATA_RST}};
      sp <= {2{can_bridge_pkg::SP_RST}};
      path <= {2{can_bridge_pkg::PATH_RST}};
      stuff_byte <= {2{can_bridge_pkg::STUFF_BYTE_RST}};
      stuff_len <= {2{can_bridge_pkg::STUFF_LEN_RST}};
      filt_st <= '0;
      filt_act <= '0;
      ent_st <= '0;
      ent_act <= '0;
      lo_st <= '0;
      lo_act <= '0;
      hi_st <= '0;
      hi_act <= '0;
      fwd_cnt <= '0;
      wr_pend <= 1'b0;
      wr_map <= 1'b0;
      wr_addr <= 9'h000;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      mode <= next_mode;
      arb <= next_arb;
      drate <= next_drate;
      sp <= next_sp;
      path <= next_path;
      stuff_byte <= next_stuff_byte;
      stuff_len <= next_stuff_len;
      filt_st <= next_filt_st;
      filt_act <= next_filt_act;
      ent_st <= next_ent_st;
      ent_act <= next_ent_act;
      lo_st <= next_lo_st;
      lo_act <= next_lo_act;
      hi_st <= next_hi_st;
      hi_act <= next_hi_act;
      fwd_cnt <= next_fwd_cnt;
      wr_pend <= next_wr_pend;
      wr_map <= next_wr_map;
      wr_addr <= next_wr_addr;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      fd_mode_o[p] = mode[p][can_bridge_pkg::MODE_FD];
      fd_iso_o[p] = mode[p][can_bridge_pkg::MODE_ISO];
      arb_rate_o[p] = arb[p];
      data_rate_o[p] = drate[p];
      sample_point_setting_o[p] = sp[p];
      fwd_pulse[p] = tx_hdr_valid_o[1 - p];
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_dir
      frame_forwarder u_fwd (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .rx_fd_mode_i(mode[g][can_bridge_pkg::MODE_FD]),
        .tx_fd_mode_i(mode[1 - g][can_bridge_pkg::MODE_FD]),
        .path_i(path[g]),
        .stuff_byte_i(stuff_byte[g]),
        .stuff_len_i(stuff_len[g]),
        .accept_i(accept[g]),
        .rx_hdr_valid_i(rx_hdr_valid_i[g]),
        .rx_id_i(rx_id_i[g]),
        .rx_ext_i(rx_ext_i[g]),
        .rx_rtr_i(rx_rtr_i[g]),
        .rx_fd_i(rx_fd_i[g]),
        .rx_brs_i(rx_brs_i[g]),
        .rx_len_i(rx_len_i[g]),
        .rx_byte_valid_i(rx_byte_valid_i[g]),
        .rx_byte_i(rx_byte_i[g]),
        .tx_hdr_valid_o(tx_hdr_valid_o[1 - g]),
        .tx_id_o(tx_id_o[1 - g]),
        .tx_ext_o(tx_ext_o[1 - g]),
        .tx_rtr_o(tx_rtr_o[1 - g]),
        .tx_fd_o(tx_fd_o[1 - g]),
        .tx_brs_o(tx_brs_o[1 - g]),
        .tx_len_o(tx_len_o[1 - g]),
        .tx_byte_valid_o(tx_byte_valid_o[1 - g]),
        .tx_byte_o(tx_byte_o[1 - g]),
        .busy_o(busy[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// File: rtl/frame_forwarder.sv
// Purpose: one forwarding direction: path choice, truncation, promotion
// Assumes: frame header then its payload bytes, one port at a time
// Notes: a header arriving while busy is dropped, there is no queue
`timescale 1ns/1ps
`default_nettype none
module frame_forwarder (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // settings
  input wire logic rx_fd_mode_i,
  input wire logic tx_fd_mode_i,
  input wire logic [5:0] path_i,
  input wire logic [7:0] stuff_byte_i,
  input wire logic [6:0] stuff_len_i,
  input wire logic accept_i,
  // received frame
  input wire logic rx_hdr_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic rx_rtr_i,
  input wire logic rx_fd_i,
  input wire logic rx_brs_i,
  input wire logic [6:0] rx_len_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  // converted frame
  output logic tx_hdr_valid_o,
  output logic [28:0] tx_id_o,
  output logic tx_ext_o,
  output logic tx_rtr_o,
  output logic tx_fd_o,
  output logic tx_brs_o,
  output logic [6:0] tx_len_o,
  output logic tx_byte_valid_o,
  output logic [7:0] tx_byte_o,
  output logic busy_o
);
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_DATA = 3'h2, S_PAD = 3'h4} fwd_state_e;
  fwd_state_e state, next_state;
  logic [6:0] idx, next_idx, in_q, next_in_q, in_len, out_len;
  logic use_cc, use_cf, use_fc, use_ff, pad, go;
  logic next_hv, next_ext, next_rtr, next_fd, next_brs, next_bv;
  logic [28:0] next_id;
  logic [6:0] next_len;
  logic [7:0] next_byte;

  always_comb begin
    use_cc = ~rx_fd_i & path_i[can_bridge_pkg::PATH_CC];
    use_cf = ~rx_fd_i & ~use_cc & tx_fd_mode_i & path_i[can_bridge_pkg::PATH_CF];
    use_ff = rx_fd_i & rx_fd_mode_i & tx_fd_mode_i & path_i[can_bridge_pkg::PATH_FF];
    use_fc = rx_fd_i & rx_fd_mode_i & ~use_ff & path_i[can_bridge_pkg::PATH_FC];
    pad = use_cf & path_i[can_bridge_pkg::PATH_STUFF] & ~rx_rtr_i
      & (rx_len_i == can_bridge_pkg::CLASSIC_MAX_LEN)
      & (stuff_len_i > can_bridge_pkg::CLASSIC_MAX_LEN) & (stuff_len_i <= can_bridge_pkg::FD_MAX_LEN);
    go = accept_i & (use_cc | use_cf | use_ff | use_fc);
    in_len = rx_rtr_i ? 7'h00 : rx_len_i;
    if (pad) begin
      out_len = stuff_len_i;
    end else if (use_fc && rx_len_i > can_bridge_pkg::CLASSIC_MAX_LEN) begin
      out_len = can_bridge_pkg::CLASSIC_MAX_LEN;
    end else begin
      out_len = rx_len_i;
    end
    next_state = state;
    next_idx = idx;
    next_in_q = in_q;
    next_hv = 1'b0;
    next_id = tx_id_o;
    next_ext = tx_ext_o;
    next_rtr = tx_rtr_o;
    next_fd = tx_fd_o;
    next_brs = tx_brs_o;
    next_len = tx_len_o;
    next_bv = 1'b0;
    next_byte = tx_byte_o;
    case (state)
      S_IDLE: begin
        if (rx_hdr_valid_i && go) begin
          next_hv = 1'b1;
          next_id = rx_id_i;
          next_ext = rx_ext_i;
          next_rtr = rx_rtr_i;
          next_fd = use_cf | use_ff;
          next_brs = use_cf ? path_i[can_bridge_pkg::PATH_BRS] : (use_ff & rx_brs_i);
          next_len = out_len;
          next_in_q = in_len;
          next_idx = 7'h00;
          if (in_len != 7'h00) begin
            next_state = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (rx_byte_valid_i) begin
          if (idx < tx_len_o) begin
            next_bv = 1'b1;
            next_byte = rx_byte_i;
          end
          next_idx = idx + 7'h01;
          if (idx + 7'h01 == in_q) begin
            next_state = (tx_len_o > in_q) ? S_PAD : S_IDLE;
          end
        end
      end
      S_PAD: begin
        next_bv = 1'b1;
        next_byte = stuff_byte_i;
        next_idx = idx + 7'h01;
        if (idx + 7'h01 == tx_len_o) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      idx <= 7'h00;
      in_q <= 7'h00;
      tx_hdr_valid_o <= 1'b0;
      tx_id_o <= 29'h0000_0000;
      tx_ext_o <= 1'b0;
      tx_rtr_o <= 1'b0;
      tx_fd_o <= 1'b0;
      tx_brs_o <= 1'b0;
      tx_len_o <= 7'h00;
      tx_byte_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      in_q <= next_in_q;
      tx_hdr_valid_o <= next_hv;
      tx_id_o <= next_id;
      tx_ext_o <= next_ext;
      tx_rtr_o <= next_rtr;
      tx_fd_o <= next_fd;
      tx_brs_o <= next_brs;
      tx_len_o <= next_len;
      tx_byte_valid_o <= next_bv;
      tx_byte_o <= next_byte;
      busy_o <= (next_state != S_IDLE);
    end
  end
endmodule
`default_nettype wire

// File: test/bridge_sva.sv
// Purpose: port checker of the frame bridge
// Assumes: one clock; filter state is internal
// Notes: filtering outcomes are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module bridge_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] rx_hdr_valid_i,
  input wire logic [1:0][28:0] rx_id_i,
  input wire logic [1:0] rx_ext_i,
  input wire logic [1:0] rx_fd_i,
  input wire logic [1:0] rx_byte_valid_i,
  input wire logic [1:0][7:0] rx_byte_i,
  input wire logic [1:0] tx_hdr_valid_o,
  input wire logic [1:0][28:0] tx_id_o,
  input wire logic [1:0] tx_ext_o,
  input wire logic [1:0] tx_fd_o,
  input wire logic [1:0] tx_brs_o,
  input wire logic [1:0][6:0] tx_len_o,
  input wire logic [1:0] tx_byte_valid_o,
  input wire logic [1:0][7:0] tx_byte_o,
  input wire logic [1:0] fd_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  bus_answer_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer");
  lane1_cause_a: assert property (tx_hdr_valid_o[1] |-> $past(rx_hdr_valid_i[0]))
    else $error("lane 1 cause");
  lane0_cause_a: assert property (tx_hdr_valid_o[0] |-> $past(rx_hdr_valid_i[1]))
    else $error("lane 0 cause");
  id_kept_a: assert property (tx_hdr_valid_o[1] |-> tx_id_o[1] == $past(rx_id_i[0])
    && tx_ext_o[1] == $past(rx_ext_i[0])) else $error("id changed");
  classic_len_a: assert property (tx_hdr_valid_o[1] && !tx_fd_o[1] |-> tx_len_o[1] <= 7'h08
    && !tx_brs_o[1]) else $error("classic length");
  classic_byte_a: assert property (tx_byte_valid_o[1] && !tx_fd_o[1] |->
    $past(rx_byte_valid_i[0]) && tx_byte_o[1] == $past(rx_byte_i[0])) else $error("classic byte");
  classic_port_a: assert property (rx_hdr_valid_i[1] && rx_fd_i[1] && !fd_mode_o[1] |=>
    !tx_hdr_valid_o[0] [*2]) else $error("classic port");
  pad_run_a: assert property (tx_byte_valid_o[0] && !$past(rx_byte_valid_i[1]) |->
    $past(tx_byte_valid_o[0]) && tx_fd_o[0]) else $error("pad run");
  cover property (tx_hdr_valid_o[1] && !tx_fd_o[1] && $past(rx_fd_i[0]));
  cover property (tx_byte_valid_o[0] && !$past(rx_byte_valid_i[1]));
  cover property (rx_hdr_valid_i[1] && rx_fd_i[1] && !fd_mode_o[1]);
endmodule
bind can_fd_bridge_forwarding bridge_sva bridge_sva_i (.*);
`default_nettype wire

// File: test/can_node_model.sv
// Purpose: far-side bus nodes feeding and draining the frame lanes
// Assumes: lane timing of the bridge frame ports
// Notes: released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  // clock
  input wire logic clk_i,
  // frames into the bridge
  output logic [1:0] rx_hdr_valid_o,
  output logic [1:0][28:0] rx_id_o,
  output logic [1:0] rx_ext_o,
  output logic [1:0] rx_rtr_o,
  output logic [1:0] rx_fd_o,
  output logic [1:0] rx_brs_o,
  output logic [1:0][6:0] rx_len_o,
  output logic [1:0] rx_byte_valid_o,
  output logic [1:0][7:0] rx_byte_o,
  // frames out of the bridge
  input wire logic [1:0] tx_hdr_valid_i,
  input wire logic [1:0] tx_byte_valid_i,
  input wire logic [1:0][7:0] tx_byte_i
);
  int hdr_cnt [2] = '{0, 0};
  logic [7:0] seen [2][$];
  initial begin
    {rx_hdr_valid_o, rx_id_o, rx_ext_o, rx_rtr_o, rx_fd_o, rx_brs_o, rx_len_o, rx_byte_valid_o, rx_byte_o} = '0;
  end
  always @(posedge clk_i) begin
    for (int q = 0; q < 2; q++) begin
      if (tx_hdr_valid_i[q] === 1'b1) hdr_cnt[q]++;
      if (tx_byte_valid_i[q] === 1'b1) seen[q].push_back(tx_byte_i[q]);
    end
  end
  // f is ext, remote, fd, brs; remote frames carry no bytes
  task automatic send(input int p, input logic [28:0] id, input logic [3:0] f, input logic [6:0] len);
    rx_hdr_valid_o[p] <= 1'b1;
    rx_id_o[p] <= id;
    {rx_ext_o[p], rx_rtr_o[p], rx_fd_o[p], rx_brs_o[p]} <= f;
    rx_len_o[p] <= len;
    @(posedge clk_i);
    rx_hdr_valid_o[p] <= 1'b0;
    rx_id_o[p] <= ~id;
    for (int i = 0; i < (f[2] ? 0 : int'(len)); i++) begin
      rx_byte_valid_o[p] <= 1'b1;
      rx_byte_o[p] <= 8'h10 + 8'(i);
      @(posedge clk_i);
    end
    rx_byte_valid_o[p] <= 1'b0;
    rx_byte_o[p] <= ~rx_byte_o[p];
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench of the two-port frame bridge
// Assumes: zero-wait ahb-lite slave, node model on both lanes
// Notes: drops judged after an 80-cycle quiet spell
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, rst_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [1:0] rx_hdr_valid_i, rx_ext_i, rx_rtr_i, rx_fd_i, rx_brs_i, rx_byte_valid_i;
  logic [1:0] tx_hdr_valid_o, tx_ext_o, tx_rtr_o, tx_fd_o, tx_brs_o, tx_byte_valid_o, fd_mode_o, fd_iso_o;
  logic [1:0][28:0] rx_id_i, tx_id_o;
  logic [1:0][6:0] rx_len_i, tx_len_o;
  logic [1:0][7:0] rx_byte_i, tx_byte_o;
  logic [1:0][13:0] arb_rate_o, data_rate_o;
  logic [1:0][31:0] sample_point_setting_o;
  int fails = 0;
  int checks = 0;
  assign hready_i = hreadyout_o;
  can_fd_bridge_forwarding can_fd_bridge_forwarding_i (.*);
  can_node_model can_node_model_i (.clk_i(clk_i), .rx_hdr_valid_o(rx_hdr_valid_i), .rx_id_o(rx_id_i),
    .rx_ext_o(rx_ext_i), .rx_rtr_o(rx_rtr_i), .rx_fd_o(rx_fd_i), .rx_brs_o(rx_brs_i), .rx_len_o(rx_len_i),
    .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i), .tx_hdr_valid_i(tx_hdr_valid_o),
    .tx_byte_valid_i(tx_byte_valid_o), .tx_byte_i(tx_byte_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // each bus phase waits up to 20 cycles for hready
  task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
    int n;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (hready_i !== 1'b1 && n < 20);
      if (hready_i !== 1'b1) begin
        fails++;
        conclude();
      end
      if (ph == 0) begin
        htrans_i <= 2'h0;
        hwdata_i <= wd;
      end
    end
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, {20'h0_0000, a}, d, x);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, {20'h0_0000, a}, 32'h0000_0000, x);
    chk($sformatf("register %h", a), x, e);
  endtask
  // eh headers expected; the rest only checked when eh is above 0
  task automatic fr(input int p, input logic [28:0] id, input logic [3:0] f, input logic [6:0] len,
    input int eh = 0, logic [6:0] el = 0, logic [1:0] efb = 0, int eb = 0, logic [7:0] lb = 0);
    int q, h;
    q = 1 - p;
    h = can_node_model_i.hdr_cnt[q];
    can_node_model_i.seen[q].delete();
    can_node_model_i.send(p, id, f, len);
    repeat (80) @(posedge clk_i);
    chk("header count", can_node_model_i.hdr_cnt[q] - h, eh);
    if (eh > 0) begin
      chk("tx length", tx_len_o[q], el);
      chk("tx id", tx_id_o[q], id);
      chk("tx flags", {tx_ext_o[q], tx_rtr_o[q], tx_fd_o[q], tx_brs_o[q]}, {f[3:2], efb});
      chk("byte count", can_node_model_i.seen[q].size(), eb);
      if (eb > 0) chk("last byte", can_node_model_i.seen[q][eb - 1], lb);
    end
  endtask
  initial begin
    {rst_n_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    hsel_i = 1'b1;
    hsize_i = can_bridge_pkg::HSIZE_WORD;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(12'h000, 32'h0000_0003);
    rd(12'h104, 32'h0000_01F4);
    rd(12'h108, 32'h0000_07D0);
    rd(12'h10C, 32'h1F40_1F40);
    rd(12'h010, 32'h0000_0009);
    rd(12'h114, 32'h0000_10FF);
    wr(12'h200, 32'h0000_0055);
    rd(12'h200, 32'h0000_0000);
    wr(12'h004, 32'h0000_0009);
    rd(12'h004, 32'h0000_01F4);
    wr(12'h004, 32'h0000_000A);
    rd(12'h004, 32'h0000_000A);
    wr(12'h004, 32'h0000_03E9);
    wr(12'h008, 32'h0000_2710);
    wr(12'h008, 32'h0000_0063);
    chk("rates out", {arb_rate_o[0], data_rate_o[0]}, 32'h0002_A710);
    wr(12'h00C, 32'h2134_1D4C);
    @(posedge clk_i);
    chk("sample point out", sample_point_setting_o[0], 32'h2134_1D4C);
    $display("test settings finished");
    wr(12'h044, 32'h0000_0100);
    wr(12'h048, 32'h0000_01FF);
    wr(12'h040, 32'h0000_0001);
    fr(0, 29'h100, 4'h0, 7'h02);
    wr(12'h01C, 32'h0000_0001);
    fr(0, 29'h100, 4'h0, 7'h02, 1, 7'h02, 2'h0, 2, 8'h11);
    fr(0, 29'h1FF, 4'h3, 7'h10, 1, 7'h10, 2'h3, 16, 8'h1F);
    fr(0, 29'h200, 4'h0, 7'h01);
    fr(0, 29'h150, 4'h8, 7'h01);
    wr(12'h054, 32'h0000_1000);
    wr(12'h058, 32'h0000_1000);
    wr(12'h050, 32'h0000_0003);
    wr(12'h018, 32'h0000_0001);
    wr(12'h01C, 32'h0000_0001);
    fr(0, 29'h150, 4'h4, 7'h00);
    fr(0, 29'h1000, 4'hC, 7'h00, 1, 7'h00, 2'h0);
    wr(12'h018, 32'h0000_0002);
    wr(12'h01C, 32'h0000_0001);
    fr(0, 29'h1000, 4'hC, 7'h00);
    $display("test filters finished");
    wr(12'h100, 32'h0000_0002);
    rd(12'h010, 32'h0000_0005);
    rd(12'h110, 32'h0000_0002);
    fr(0, 29'h120, 4'h2, 7'h0C, 1, 7'h08, 2'h0, 8, 8'h17);
    wr(12'h000, 32'h0000_0001);
    @(posedge clk_i);
    chk("fd variant out", {30'h0, fd_iso_o}, 32'h0000_0002);
    wr(12'h144, 32'h0000_0000);
    wr(12'h148, 32'h0000_07FF);
    wr(12'h140, 32'h0000_0001);
    wr(12'h11C, 32'h0000_0001);
    wr(12'h110, 32'h0000_0032);
    wr(12'h114, 32'h0000_18A5);
    fr(1, 29'h111, 4'h0, 7'h08, 1, 7'h18, 2'h3, 24, 8'hA5);
    fr(1, 29'h111, 4'h0, 7'h03, 1, 7'h03, 2'h3, 3, 8'h12);
    wr(12'h110, 32'h0000_0002);
    fr(1, 29'h111, 4'h0, 7'h08, 1, 7'h08, 2'h2, 8, 8'h17);
    fr(1, 29'h111, 4'h2, 7'h08);
    $display("test conversion finished");
    conclude();
  end
endmodule
`default_nettype wire
